/* verilog/ulpc_regs.sv */
// Transceiver control register bank: link-side registers, transceiver-side controls
`timescale 1ns/10ps
module ulpc_regs
  import ulpc_pkg::*;
#(
  parameter logic [7:0] PRODUCT_ID_UPPER = PRODUCT_ID_UPPER_DEFAULT,  // Arbitrary value
  parameter int         RESET_CYCLES     = XCVR_RESET_CYC
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     clk_link,
  input  wire logic [5:0]               reg_addr,
  input  wire logic                     reg_wr_en,
  input  wire logic                     reg_rd_en,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  output logic                          reg_rdata_valid,
  input  wire logic                     host_mode_in,
  input  wire logic                     lp_exit_req_in,
  input  wire logic                     serial_exit_req_in,
  input  wire logic                     vbus_comparator_in,
  input  wire logic                     external_vbus_indicator_in,
  output ulpc_pkg::ulpc_xcvr_ctl_t      xcvr_ctl,
  output logic                          xcvr_reset_out,
  output logic                          charge_pump_enable_out
);
  import ulpc_pkg::*;

  typedef enum logic [1:0] {RST_IDLE, RST_RUN, RST_DONE} ulpc_rst_state_t;

  function automatic logic [7:0] ulpc_apply(input logic [7:0] cur, input logic [5:0] addr,
                                            input logic [5:0] base, input logic [7:0] wd);
    logic [7:0] r;
    r = cur;
    if (addr == base)                      r = wd;
    else if (addr == base + OFS_SET)       r = cur | wd;
    else if (addr == base + OFS_CLR)       r = cur & ~wd;
    return r;
  endfunction : ulpc_apply

  function automatic logic ulpc_hit(input logic [5:0] addr, input logic [5:0] base);
    return (addr >= base) && (addr <= base + OFS_CLR);
  endfunction : ulpc_hit

  // ----------------------------------------------------------------
  // Link domain: register array
  // ----------------------------------------------------------------
  ulpc_func_t  func_q,  func_d;
  ulpc_iface_t iface_q, iface_d;
  ulpc_otg_t   otg_q,   otg_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  // Events back from clk_sys: done level, two toggles
  logic [2:0]  done_sync_q, lp_sync_q, ser_sync_q;
  logic        done_evt, lp_evt, ser_evt;
  logic        rst_done_q, lp_tgl_q, ser_tgl_q;

  assign done_evt = done_sync_q[1] & ~done_sync_q[2];
  assign lp_evt   = lp_sync_q[1] ^ lp_sync_q[2];
  assign ser_evt  = ser_sync_q[1] ^ ser_sync_q[2];

  always_comb begin
    logic [7:0] f;
    logic [7:0] i;
    f = func_q;
    i = iface_q;
    // Hardware clears go first so a simultaneous software set survives
    if (done_evt) f[5] = 1'b0;
    if (ser_evt)  i[2:0] = 3'b000;
    if (reg_wr_en) begin
      f = ulpc_apply(f, reg_addr, ADDR_FUNC_BASE, reg_wdata) & FUNC_WMASK;
      i = ulpc_apply(i, reg_addr, ADDR_IFACE_BASE, reg_wdata);
    end
    // Hardware set last so it wins over a software clear
    if (lp_evt) f[6] = 1'b1;
    func_d  = ulpc_func_t'(f);
    iface_d = ulpc_iface_t'(i);
    otg_d   = reg_wr_en ? ulpc_otg_t'(ulpc_apply(otg_q, reg_addr, ADDR_OTG_BASE, reg_wdata)) : otg_q;
    rvalid_d = reg_rd_en;
    rdata_d  = 8'h00;
    if (reg_rd_en) begin
      if (reg_addr == ADDR_PRODUCT_ID_UPPER)       rdata_d = PRODUCT_ID_UPPER;
      else if (ulpc_hit(reg_addr, ADDR_FUNC_BASE))  rdata_d = func_q;
      else if (ulpc_hit(reg_addr, ADDR_IFACE_BASE)) rdata_d = iface_q;
      else if (ulpc_hit(reg_addr, ADDR_OTG_BASE))   rdata_d = otg_q;
    end
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      func_q      <= ulpc_func_t'(FUNC_RESET);
      iface_q     <= ulpc_iface_t'(IFACE_RESET);
      otg_q       <= ulpc_otg_t'(OTG_RESET);
      rdata_q     <= 8'h00;
      rvalid_q    <= 1'b0;
      done_sync_q <= 3'b000;
      lp_sync_q   <= 3'b000;
      ser_sync_q  <= 3'b000;
    end else begin
      func_q      <= func_d;
      iface_q     <= iface_d;
      otg_q       <= otg_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
      done_sync_q <= {done_sync_q[1:0], rst_done_q};
      lp_sync_q   <= {lp_sync_q[1:0], lp_tgl_q};
      ser_sync_q  <= {ser_sync_q[1:0], ser_tgl_q};
    end
  end

  assign reg_rdata       = rdata_q;
  assign reg_rdata_valid = rvalid_q;

  // ----------------------------------------------------------------
  // Sys domain: configuration crossing
  // ----------------------------------------------------------------
  // Bits may skew through the synchronisers; a word is taken only once two samples agree.
  ulpc_cfg_t       cfg_s1_q, cfg_s2_q, cfg_s3_q, cfg_q, cfg_d;
  logic [2:0]      pin_s1_q, pin_s2_q;
  logic [1:0]      vbus_s1_q, vbus_s2_q;
  logic            host_mode, lp_exit_req, serial_exit_req, vbus_int, vbus_ext;
  ulpc_rst_state_t rst_state_q, rst_state_d;
  logic [15:0]     rst_cnt_q, rst_cnt_d;
  logic            rst_done_d;
  logic            lp_tgl_d, lp_pend_q, lp_pend_d;
  logic            ser_tgl_d, ser_pend_q, ser_pend_d;
  ulpc_xcvr_ctl_t  ctl_q, ctl_d;
  logic            xrst_q, xrst_d, charge_pump_enable_out_q, charge_pump_enable_out_d;
  logic            serial_any;

  assign {host_mode, lp_exit_req, serial_exit_req} = pin_s2_q;
  assign {vbus_int, vbus_ext}                       = vbus_s2_q;
  assign serial_any = cfg_q.iface.six_pin_serial_enable | cfg_q.iface.three_pin_serial_enable
                    | cfg_q.iface.accessory_uart_enable;

  always_comb begin
    logic vind;
    vind  = 1'b0;
    cfg_d = (cfg_s2_q == cfg_s3_q) ? cfg_s3_q : cfg_q;

    // Transceiver reset handshake: hold, report done, wait for the bit to drop
    rst_state_d = rst_state_q;
    rst_cnt_d   = rst_cnt_q;
    rst_done_d  = 1'b0;
    xrst_d      = 1'b0;
    case (rst_state_q)
      RST_IDLE: begin
        rst_cnt_d = 16'h0000;
        if (cfg_q.func.xcvr_reset) begin
          rst_state_d = RST_RUN;
          xrst_d      = 1'b1;
        end
      end
      RST_RUN: begin
        xrst_d    = 1'b1;
        rst_cnt_d = rst_cnt_q + 16'h0001;
        if (rst_cnt_q == 16'(RESET_CYCLES - 1)) begin
          rst_state_d = RST_DONE;
          xrst_d      = 1'b0;
        end
      end
      RST_DONE: begin
        rst_done_d = 1'b1;
        if (!cfg_q.func.xcvr_reset) begin
          rst_state_d = RST_IDLE;
          rst_done_d  = 1'b0;
        end
      end
      default: rst_state_d = RST_IDLE;
    endcase

    // Exit requests become one toggle each, then wait for the register to follow
    lp_tgl_d  = lp_tgl_q;
    lp_pend_d = lp_pend_q & ~cfg_q.func.suspend_n;
    if (!cfg_q.func.suspend_n && lp_exit_req && !lp_pend_q) begin
      lp_tgl_d  = ~lp_tgl_q;
      lp_pend_d = 1'b1;
    end
    ser_tgl_d  = ser_tgl_q;
    ser_pend_d = ser_pend_q & serial_any;
    if (serial_any && serial_exit_req && !ser_pend_q) begin
      ser_tgl_d  = ~ser_tgl_q;
      ser_pend_d = 1'b1;
    end

    ctl_d.speed            = cfg_q.func.transceiver_speed_select;
    ctl_d.fs_preamble_en   = cfg_q.func.transceiver_speed_select == SPEED_LS_ON_FS;
    ctl_d.hs_term_en       = cfg_q.func.transceiver_speed_select == SPEED_HS
                           && !cfg_q.func.termination_select
                           && cfg_q.func.transmit_encoding_mode != ENC_NODRIVE;
    ctl_d.dp_pullup_en     = cfg_q.func.termination_select
                           && (cfg_q.func.transceiver_speed_select == SPEED_FS
                           || cfg_q.func.transceiver_speed_select == SPEED_LS_ON_FS)
                           && !cfg_q.otg.dplus_pulldown_enable;
    ctl_d.dm_pullup_en     = cfg_q.func.termination_select
                           && cfg_q.func.transceiver_speed_select == SPEED_LS
                           && !cfg_q.otg.dminus_pulldown_enable;
    ctl_d.dp_pulldown_en   = cfg_q.otg.dplus_pulldown_enable;
    ctl_d.dm_pulldown_en   = cfg_q.otg.dminus_pulldown_enable;
    ctl_d.tx_drive_en      = cfg_q.func.transmit_encoding_mode != ENC_NODRIVE;
    ctl_d.bitstuff_nrzi_en = cfg_q.func.transmit_encoding_mode != ENC_RAW;
    ctl_d.low_power        = !cfg_q.func.suspend_n;
    ctl_d.six_pin_serial   = cfg_q.iface.six_pin_serial_enable;
    ctl_d.three_pin_serial = cfg_q.iface.three_pin_serial_enable;
    ctl_d.accessory_uart   = cfg_q.iface.accessory_uart_enable;
    ctl_d.interface_clock_run = cfg_q.func.suspend_n
                              && (!serial_any || cfg_q.iface.clock_keep_running);
    ctl_d.auto_resume_en   = cfg_q.iface.auto_resume_signaling & host_mode;
    ctl_d.stop_pullup_en   = !cfg_q.iface.stop_pullup_disable;
    ctl_d.id_pullup_en     = cfg_q.otg.id_pin_pullup_enable;
    ctl_d.vbus_discharge_en = cfg_q.otg.vbus_discharge_enable;
    ctl_d.vbus_charge_en   = cfg_q.otg.vbus_charge_enable;
    vind = vbus_ext ^ cfg_q.iface.vbus_indicator_invert;
    if (cfg_q.otg.vbus_valid_source_select)
      ctl_d.vbus_valid = vind;
    else if (cfg_q.iface.vbus_indicator_bypass_and)
      ctl_d.vbus_valid = vbus_int;
    else
      ctl_d.vbus_valid = vbus_int & vind;
    charge_pump_enable_out_d = cfg_q.otg.vbus_drive_enable | cfg_q.otg.vbus_drive_enable_alt;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Start at the reset word so no all-zero word is taken after release
      cfg_s1_q    <= {FUNC_RESET, IFACE_RESET, OTG_RESET};
      cfg_s2_q    <= {FUNC_RESET, IFACE_RESET, OTG_RESET};
      cfg_s3_q    <= {FUNC_RESET, IFACE_RESET, OTG_RESET};
      cfg_q       <= {FUNC_RESET, IFACE_RESET, OTG_RESET};
      pin_s1_q    <= 3'b000;
      pin_s2_q    <= 3'b000;
      vbus_s1_q   <= 2'b00;
      vbus_s2_q   <= 2'b00;
      rst_state_q <= RST_IDLE;
      rst_cnt_q   <= 16'h0000;
      rst_done_q  <= 1'b0;
      lp_tgl_q    <= 1'b0;
      lp_pend_q   <= 1'b0;
      ser_tgl_q   <= 1'b0;
      ser_pend_q  <= 1'b0;
      ctl_q       <= '0;
      xrst_q      <= 1'b0;
      charge_pump_enable_out_q      <= 1'b0;
    end else begin
      cfg_s1_q    <= {func_q, iface_q, otg_q};
      cfg_s2_q    <= cfg_s1_q;
      cfg_s3_q    <= cfg_s2_q;
      cfg_q       <= cfg_d;
      pin_s1_q    <= {host_mode_in, lp_exit_req_in, serial_exit_req_in};
      pin_s2_q    <= pin_s1_q;
      vbus_s1_q   <= {vbus_comparator_in, external_vbus_indicator_in};
      vbus_s2_q   <= vbus_s1_q;
      rst_state_q <= rst_state_d;
      rst_cnt_q   <= rst_cnt_d;
      rst_done_q  <= rst_done_d;
      lp_tgl_q    <= lp_tgl_d;
      lp_pend_q   <= lp_pend_d;
      ser_tgl_q   <= ser_tgl_d;
      ser_pend_q  <= ser_pend_d;
      ctl_q       <= ctl_d;
      xrst_q      <= xrst_d;
      charge_pump_enable_out_q      <= charge_pump_enable_out_d;
    end
  end

  assign xcvr_ctl               = ctl_q;
  assign xcvr_reset_out         = xrst_q;
  assign charge_pump_enable_out = charge_pump_enable_out_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_read_alias: assert property (@(posedge clk_link) disable iff (rst)
    reg_rd_en && reg_addr == ADDR_OTG_BASE + OFS_CLR |=> reg_rdata_valid && reg_rdata == $past(otg_q))
    else $error("OTG read alias mismatch");

  chk_set_bits: assert property (@(posedge clk_link) disable iff (rst)
    reg_wr_en && reg_addr == ADDR_OTG_BASE + OFS_SET
    |=> (otg_q & $past(reg_wdata)) == $past(reg_wdata) && (otg_q & ~$past(reg_wdata)) == ($past(otg_q) & ~$past(reg_wdata)))
    else $error("Set write changed wrong bits");

  chk_clear_bits: assert property (@(posedge clk_link) disable iff (rst)
    reg_wr_en && reg_addr == ADDR_OTG_BASE + OFS_CLR |=> (otg_q & $past(reg_wdata)) == 8'h00)
    else $error("Clear write left bits set");

  chk_reserved_zero: assert property (@(posedge clk_link) disable iff (rst)
    func_q.reserved == 1'b0)
    else $error("Reserved control bit set");

  chk_preamble_sel: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(cfg_q.func.transceiver_speed_select)
    |=> ctl_q.fs_preamble_en == ($past(cfg_q.func.transceiver_speed_select) == SPEED_LS_ON_FS))
    else $error("Preamble enable does not follow speed");

  chk_reset_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(xcvr_reset_out) |-> xcvr_reset_out [*8])
    else $error("Transceiver reset too short");

  chk_suspend_exit: assert property (@(posedge clk_link) disable iff (rst)
    lp_evt |=> func_q.suspend_n)
    else $error("Suspend bit not set on exit");

  chk_serial_exit: assert property (@(posedge clk_link) disable iff (rst)
    ser_evt && !reg_wr_en |=> iface_q[2:0] == 3'b000)
    else $error("Serial mode bits not cleared on exit");

  chk_clock_stop: assert property (@(posedge clk_sys) disable iff (rst)
    serial_any && !cfg_q.iface.clock_keep_running |=> !ctl_q.interface_clock_run)
    else $error("Output clock runs in serial mode");

  chk_charge_pump: assert property (@(posedge clk_sys) disable iff (rst)
    (cfg_q.otg.vbus_drive_enable || cfg_q.otg.vbus_drive_enable_alt) |=> charge_pump_enable_out)
    else $error("Charge pump not enabled");

  chk_hs_term: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_q.func.transceiver_speed_select == SPEED_HS && !cfg_q.func.termination_select
    && cfg_q.func.transmit_encoding_mode == ENC_NORMAL |=> xcvr_ctl.hs_term_en)
    else $error("High-speed termination missing");

  chk_nodrive_mode: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_q.func.transmit_encoding_mode == ENC_NODRIVE |=> !xcvr_ctl.tx_drive_en && !xcvr_ctl.hs_term_en)
    else $error("Transmitter drives in non-driving mode");

  chk_raw_encoding: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_q.func.transmit_encoding_mode == ENC_RAW |=> !xcvr_ctl.bitstuff_nrzi_en)
    else $error("Bit stuffing still on in raw mode");

  // Done goes to the link side and the cleared bit returns; about 10 sys cycles
  chk_reset_selfclear: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(xcvr_reset_out) |-> ##[1:40] !cfg_q.func.xcvr_reset)
    else $error("Reset bit did not clear itself");

  chk_low_power: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_q.func.suspend_n |=> xcvr_ctl.low_power && !xcvr_ctl.interface_clock_run)
    else $error("Suspend did not enter low power");

  chk_resume_host: assert property (@(posedge clk_sys) disable iff (rst)
    !host_mode |=> !xcvr_ctl.auto_resume_en)
    else $error("Auto resume enabled outside host mode");

  chk_pulldown_follow: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> xcvr_ctl.dp_pulldown_en == $past(cfg_q.otg.dplus_pulldown_enable)
    && xcvr_ctl.dm_pulldown_en == $past(cfg_q.otg.dminus_pulldown_enable))
    else $error("Line pull-downs do not follow register");

  chk_pump_off: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_q.otg.vbus_drive_enable && !cfg_q.otg.vbus_drive_enable_alt |=> !charge_pump_enable_out)
    else $error("Charge pump on with both drive bits clear");

  chk_vbus_external: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_q.otg.vbus_valid_source_select
    |=> xcvr_ctl.vbus_valid == $past(vbus_ext ^ cfg_q.iface.vbus_indicator_invert))
    else $error("Valid source ignores external indicator");

endmodule : ulpc_regs

/* pkg/ulpc_pkg.sv */
// Constants and carrier types for the transceiver control register bank
package ulpc_pkg;

  // ----------------------------------------------------------------
  // Register addresses (6-bit register space)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_PRODUCT_ID_UPPER = 6'h03;
  localparam logic [5:0] ADDR_FUNC_BASE        = 6'h04;
  localparam logic [5:0] ADDR_IFACE_BASE       = 6'h07;
  localparam logic [5:0] ADDR_OTG_BASE         = 6'h0a;
  localparam logic [5:0] OFS_SET               = 6'h01;
  localparam logic [5:0] OFS_CLR               = 6'h02;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] FUNC_RESET  = 8'h41;
  localparam logic [7:0] IFACE_RESET = 8'h00;
  localparam logic [7:0] OTG_RESET   = 8'h06;
  localparam logic [7:0] FUNC_WMASK  = 8'h7f;
  localparam logic [7:0] PRODUCT_ID_UPPER_DEFAULT = 8'h5a;  // Arbitrary value

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SPEED_HS      = 2'b00;
  localparam logic [1:0] SPEED_FS      = 2'b01;
  localparam logic [1:0] SPEED_LS      = 2'b10;
  localparam logic [1:0] SPEED_LS_ON_FS = 2'b11;
  localparam logic [1:0] ENC_NORMAL    = 2'b00;
  localparam logic [1:0] ENC_NODRIVE   = 2'b01;
  localparam logic [1:0] ENC_RAW       = 2'b10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_SYS_NS      = 25;
  localparam int XCVR_RESET_NS   = 1000;
  localparam int XCVR_RESET_CYC  = (XCVR_RESET_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reserved;
    logic       suspend_n;
    logic       xcvr_reset;
    logic [1:0] transmit_encoding_mode;
    logic       termination_select;
    logic [1:0] transceiver_speed_select;
  } ulpc_func_t;

  typedef struct packed {
    logic stop_pullup_disable;
    logic vbus_indicator_bypass_and;
    logic vbus_indicator_invert;
    logic auto_resume_signaling;
    logic clock_keep_running;
    logic accessory_uart_enable;
    logic three_pin_serial_enable;
    logic six_pin_serial_enable;
  } ulpc_iface_t;

  typedef struct packed {
    logic vbus_valid_source_select;
    logic vbus_drive_enable_alt;
    logic vbus_drive_enable;
    logic vbus_charge_enable;
    logic vbus_discharge_enable;
    logic dminus_pulldown_enable;
    logic dplus_pulldown_enable;
    logic id_pin_pullup_enable;
  } ulpc_otg_t;

  typedef struct packed {
    ulpc_func_t  func;
    ulpc_iface_t iface;
    ulpc_otg_t   otg;
  } ulpc_cfg_t;

  // Transceiver-side controls, all registered on clk_sys
  typedef struct packed {
    logic [1:0] speed;
    logic       fs_preamble_en;
    logic       hs_term_en;
    logic       dp_pullup_en;
    logic       dm_pullup_en;
    logic       dp_pulldown_en;
    logic       dm_pulldown_en;
    logic       tx_drive_en;
    logic       bitstuff_nrzi_en;
    logic       low_power;
    logic       six_pin_serial;
    logic       three_pin_serial;
    logic       accessory_uart;
    logic       interface_clock_run;
    logic       auto_resume_en;
    logic       stop_pullup_en;
    logic       id_pullup_en;
    logic       vbus_discharge_en;
    logic       vbus_charge_en;
    logic       vbus_valid;
  } ulpc_xcvr_ctl_t;

endpackage : ulpc_pkg

/* test/ulpc_link_model.sv */
// Link controller model driving the register port of the bank
`timescale 1ns/10ps
module ulpc_link_model (
  input  wire logic       clk_link,
  output logic      [5:0] reg_addr,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rdata_valid
);
  initial begin
    reg_addr  = 6'h3f;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse of the last value, never a stale match
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_link);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(negedge clk_link);
    reg_wr_en <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    int i;
    @(negedge clk_link);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(negedge clk_link);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    for (i = 0; i < 4 && reg_rdata_valid !== 1'b1; i++) @(negedge clk_link);
    d = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd
endmodule : ulpc_link_model

/* test/testbench.sv */
// Self-checking bench for the transceiver control register bank
`timescale 1ns/10ps
module testbench;
  import ulpc_pkg::*;
  typedef struct packed { logic [5:0] a; logic w; logic [7:0] d; } ulpc_row_t;
  localparam int RC = 8;
  localparam ulpc_row_t ROWS [30] = '{
    '{6'h03,1'b0,PRODUCT_ID_UPPER_DEFAULT}, '{6'h04,1'b0,8'h41}, '{6'h05,1'b0,8'h41}, '{6'h06,1'b0,8'h41},
    '{6'h07,1'b0,8'h00}, '{6'h08,1'b0,8'h00}, '{6'h09,1'b0,8'h00}, '{6'h0a,1'b0,8'h06},
    '{6'h0b,1'b0,8'h06}, '{6'h0c,1'b0,8'h06}, '{6'h0d,1'b0,8'h00}, '{6'h03,1'b1,8'hff},
    '{6'h03,1'b0,PRODUCT_ID_UPPER_DEFAULT}, '{6'h04,1'b1,8'hc3}, '{6'h04,1'b0,8'h43}, '{6'h05,1'b1,8'h0c},
    '{6'h05,1'b0,8'h4f}, '{6'h06,1'b1,8'h03}, '{6'h06,1'b0,8'h4c}, '{6'h07,1'b1,8'hf8},
    '{6'h08,1'b0,8'hf8}, '{6'h09,1'b1,8'hf0}, '{6'h09,1'b0,8'h08}, '{6'h0a,1'b1,8'h81},
    '{6'h0a,1'b0,8'h81}, '{6'h0b,1'b1,8'h60}, '{6'h0b,1'b0,8'he1}, '{6'h0c,1'b1,8'h81},
    '{6'h0c,1'b0,8'h60}, '{6'h07,1'b1,8'h00}};
  logic clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1;
  logic host_mode_in = 1'b0, lp_exit_req_in = 1'b0, serial_exit_req_in = 1'b0;
  logic vbus_comparator_in = 1'b0, external_vbus_indicator_in = 1'b1;
  logic [5:0] reg_addr;
  logic reg_wr_en, reg_rd_en, reg_rdata_valid, xcvr_reset_out, charge_pump_enable_out;
  logic [7:0] reg_wdata, reg_rdata, got;
  ulpc_xcvr_ctl_t xcvr_ctl;
  int n_fail = 0, checks_done = 0, k, n;

  always #12.5 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #24 clk_link = ~clk_link;
  end

  ulpc_regs #(.RESET_CYCLES(RC)) i_ulpc_regs (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .host_mode_in(host_mode_in),
    .lp_exit_req_in(lp_exit_req_in), .serial_exit_req_in(serial_exit_req_in),
    .vbus_comparator_in(vbus_comparator_in), .external_vbus_indicator_in(external_vbus_indicator_in),
    .xcvr_ctl(xcvr_ctl), .xcvr_reset_out(xcvr_reset_out), .charge_pump_enable_out(charge_pump_enable_out));
  ulpc_link_model i_ulpc_link_model (.clk_link(clk_link), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Covers the clock crossing plus the pair-match compare on the sys side
  task automatic settle();
    repeat (24) @(negedge clk_sys);
  endtask : settle

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_ulpc_link_model.wr(a, d);
    settle();
  endtask : wr

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial begin
    #400us;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    settle();
    chk("dp_pulldown reset", 8'h01, xcvr_ctl.dp_pulldown_en);
    foreach (ROWS[i]) begin
      if (ROWS[i].w) i_ulpc_link_model.wr(ROWS[i].a, ROWS[i].d);
      else begin
        i_ulpc_link_model.rd(ROWS[i].a, got);
        chk($sformatf("reg %h", ROWS[i].a), ROWS[i].d, got);
      end
    end
    $display("test table done");
    // ----------------------------------------------------------------
    // Speed, encoding and termination
    // ----------------------------------------------------------------
    for (k = 0; k < 4; k++) begin
      wr(6'h04, 8'h40 | 8'(k));
      chk("speed", 8'(k), xcvr_ctl.speed);
      chk("preamble", 8'(k == 3), xcvr_ctl.fs_preamble_en);
    end
    for (k = 0; k < 3; k++) begin
      wr(6'h04, 8'h41 | 8'(k << 3));
      chk("tx_drive", 8'(k != 1), xcvr_ctl.tx_drive_en);
      chk("bitstuff", 8'(k != 2), xcvr_ctl.bitstuff_nrzi_en);
    end
    wr(6'h04, 8'h40);
    chk("hs_term", 8'h01, xcvr_ctl.hs_term_en);
    wr(6'h0a, 8'h00);
    wr(6'h04, 8'h46);
    chk("dm_pullup ls", 8'h01, xcvr_ctl.dm_pullup_en);
    wr(6'h04, 8'h45);
    chk("dp_pullup", 8'h01, xcvr_ctl.dp_pullup_en);
    chk("dm_pullup", 8'h00, xcvr_ctl.dm_pullup_en);
    $display("test speed done");
    // ----------------------------------------------------------------
    // OTG controls and charge pump
    // ----------------------------------------------------------------
    wr(6'h0a, 8'h99);
    chk("id_pullup", 8'h01, xcvr_ctl.id_pullup_en);
    chk("dp_pulldown", 8'h00, xcvr_ctl.dp_pulldown_en);
    chk("dm_pulldown", 8'h00, xcvr_ctl.dm_pulldown_en);
    chk("discharge", 8'h01, xcvr_ctl.vbus_discharge_en);
    chk("charge", 8'h01, xcvr_ctl.vbus_charge_en);
    chk("vbus_ext", 8'h01, xcvr_ctl.vbus_valid);
    wr(6'h07, 8'h20);
    chk("vbus_inv", 8'h00, xcvr_ctl.vbus_valid);
    wr(6'h0a, 8'h06);
    wr(6'h07, 8'h40);
    vbus_comparator_in = 1'b1;
    external_vbus_indicator_in = 1'b0;
    settle();
    chk("vbus_bypass", 8'h01, xcvr_ctl.vbus_valid);
    wr(6'h07, 8'h80);
    chk("vbus_and", 8'h00, xcvr_ctl.vbus_valid);
    chk("stop_pullup", 8'h00, xcvr_ctl.stop_pullup_en);
    external_vbus_indicator_in = 1'b1;
    for (k = 0; k < 3; k++) begin
      wr(6'h0a, 8'h06 | 8'(8'h20 << k));
      chk("charge_pump", 8'(k < 2), charge_pump_enable_out);
    end
    $display("test otg done");
    // ----------------------------------------------------------------
    // Self-clearing bits and hardware exits
    // ----------------------------------------------------------------
    i_ulpc_link_model.wr(6'h05, 8'h20);
    for (k = 0; k < 80 && xcvr_reset_out !== 1'b1; k++) @(negedge clk_sys);
    for (n = 0; n < 100 && xcvr_reset_out === 1'b1; n++) @(negedge clk_sys);
    chk("reset_len", 8'(RC), 8'(n));
    settle();
    i_ulpc_link_model.rd(6'h04, got);
    chk("reset_clear", 8'h45, got);
    wr(6'h06, 8'h40);
    chk("low_power", 8'h01, xcvr_ctl.low_power);
    lp_exit_req_in = 1'b1;
    settle();
    lp_exit_req_in = 1'b0;
    i_ulpc_link_model.rd(6'h04, got);
    chk("suspend_set", 8'h45, got);
    for (k = 0; k < 3; k++) begin
      wr(6'h07, 8'(1 << k));
      chk("serial", 8'(1 << k), {xcvr_ctl.accessory_uart, xcvr_ctl.three_pin_serial, xcvr_ctl.six_pin_serial});
      chk("clk_stop", 8'h00, xcvr_ctl.interface_clock_run);
      wr(6'h08, 8'h08);
      chk("clk_keep", 8'h01, xcvr_ctl.interface_clock_run);
      serial_exit_req_in = 1'b1;
      settle();
      serial_exit_req_in = 1'b0;
      i_ulpc_link_model.rd(6'h07, got);
      chk("serial_exit", 8'h08, got);
    end
    wr(6'h07, 8'h10);
    chk("resume_dev", 8'h00, xcvr_ctl.auto_resume_en);
    host_mode_in = 1'b1;
    settle();
    chk("resume_host", 8'h01, xcvr_ctl.auto_resume_en);
    $display("test exits done");
    // ----------------------------------------------------------------
    // Reset in mid-run
    // ----------------------------------------------------------------
    rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("resume_in_reset", 8'h00, xcvr_ctl.auto_resume_en);
    rst = 1'b0;
    settle();
    chk("dm_pulldown reset", 8'h01, xcvr_ctl.dm_pulldown_en);
    i_ulpc_link_model.rd(6'h04, got);
    chk("func reset", 8'h41, got);
    i_ulpc_link_model.rd(6'h07, got);
    chk("iface reset", 8'h00, got);
    i_ulpc_link_model.rd(6'h0a, got);
    chk("otg reset", 8'h06, got);
    $display("test reset done");
    close_out();
  end
endmodule : testbench
